// [rtl/sdc_pkg.sv]
// shared constants and types for the synchronous dram device model
package sdc_pkg;
    // ------------------------------------------------------------
    // pin and array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int LANES = 2;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int MODE_W = 15;
    localparam int ROW_BITS_DEF = 13;
    localparam int COL_BITS_DEF = 9;
    localparam int AP_BIT = 10;
    // ------------------------------------------------------------
    // command codes: {chip select, row strobe, column strobe, write enable}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_OP_LSB = 7;
    localparam int MODE_WB_BIT = 9;
    localparam logic [MODE_W-1:0] MODE_RESET = 15'h0000;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_MIN = 3'h1;
    localparam logic [2:0] CL_MAX = 3'h3;
    localparam int PIPE_D = 2;
    // ------------------------------------------------------------
    // timing: start-up quiet time the controller must respect
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int INIT_TIME_US = 100;
    localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
    // ------------------------------------------------------------
    // power / clock-enable states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        PWR_RUN = 5'h01,
        PWR_SUSPEND = 5'h02,
        PWR_PD_PRE = 5'h04,
        PWR_PD_ACT = 5'h08,
        PWR_SELF_REF = 5'h10
    } sdc_pwr_type;
endpackage : sdc_pkg

// [rtl/sdc_sdram_device.sv]
// quad-bank synchronous dram device: command decode, bursts, masks, power states
//
// What this block does
// - all inputs except the asynchronous nrst are captured on the rising edge of ref_clk.
// - four banks of 8192 rows by 512 columns of 16-bit words.
// - activate takes the row number from the thirteen address inputs.
// - read/write take start column from low nine bits; bit ten selects auto precharge.
// - auto precharge closes the row by itself when the burst ends.
// - burst lengths 1, 2, 4, 8 or full page; terminate cuts bursts short.
// - following columns come from an internal counter in the programmed order.
// - a new column command is accepted on every clock, even mid-burst.
// - one bank may be precharged while another bank is accessed.
// - the two bank selects choose the bank for activate, read, write, precharge.
// - precharge closes all banks when bit ten high, else the selected one.
// - load mode takes its op-code from address and bank-select inputs.
// - chip select high masks the command on that edge.
// - command is decoded from strobes and chip select on one edge.
// - clock enable low gives power-down, self refresh or clock suspend by state.
// - in power-down or self refresh clock enable acts to exit immediately.
// - a masked byte is not stored during a write.
// - a masked byte is high impedance two clocks after the mask during reads.
// - lower mask governs bits 7..0, upper mask governs bits 15..8.
// - mode holds length, type, read latency, operating mode, write burst mode.
`timescale 1ns/1ps
`default_nettype none
module sdc_sdram_device #(
    parameter int ROW_BITS = sdc_pkg::ROW_BITS_DEF,
    parameter int COL_BITS = sdc_pkg::COL_BITS_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_sel_0,
    input wire logic bank_sel_1,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    input wire logic [sdc_pkg::DATA_W-1:0] data_lines_in,
    output logic [sdc_pkg::DATA_W-1:0] data_lines_out,
    output logic [sdc_pkg::LANES-1:0] data_lines_oe_n
);
    import sdc_pkg::*;

    localparam int IDX_W = BANK_W + ROW_BITS + COL_BITS;

    typedef struct packed {
        sdc_pwr_type pwr;
        logic [BANKS-1:0] bank_open;
        logic [BANKS-1:0][ROW_BITS-1:0] row;
        logic [MODE_W-1:0] mode;
        logic bst_act;
        logic bst_wr;
        logic bst_ap;
        logic [BANK_W-1:0] bst_bank;
        logic [COL_BITS-1:0] bst_col;
        logic [COL_BITS-1:0] bst_cnt;
        logic [COL_BITS:0] bst_len;
        logic [PIPE_D-1:0] pvld;
        logic [PIPE_D-1:0][DATA_W-1:0] pdat;
        logic [LANES-1:0] mask_q;
        logic [DATA_W-1:0] dout;
        logic dvld;
        logic [LANES-1:0] doe_n;
    } sdc_state_type;

    localparam sdc_state_type ST_RESET = '{pwr: PWR_RUN, mode: MODE_RESET,
                                           doe_n: {LANES{1'b1}}, default: '0};

    // ------------------------------------------------------------
    // storage: one flat array, bank/row/column concatenated
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:(1<<IDX_W)-1];

    sdc_state_type st_q;
    sdc_state_type st_d;
    logic [3:0] cmd;
    logic [BANK_W-1:0] ba;
    logic [LANES-1:0] mask_in;
    logic [2:0] cl_use;
    logic [COL_BITS:0] new_len;
    logic acc_en;
    logic acc_wr;
    logic acc_last;
    logic acc_ap;
    logic [BANK_W-1:0] acc_bank;
    logic [COL_BITS-1:0] acc_col;
    logic [IDX_W-1:0] acc_idx;
    logic [DATA_W-1:0] rd_word;
    logic rvld;
    logic full_pg;

    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign ba = {bank_sel_1, bank_sel_0};
    assign mask_in = {upper_byte_mask, lower_byte_mask};
    assign data_lines_out = st_q.dout;
    assign data_lines_oe_n = st_q.doe_n;

    // ------------------------------------------------------------
    // burst helpers
    // ------------------------------------------------------------
    function automatic logic [COL_BITS:0] bl_len(input logic [2:0] code);
        bl_len = (COL_BITS+1)'(1);
        case (code)
            BL_2: bl_len = (COL_BITS+1)'(2);
            BL_4: bl_len = (COL_BITS+1)'(4);
            BL_8: bl_len = (COL_BITS+1)'(8);
            BL_PAGE: bl_len = (COL_BITS+1)'(1) << COL_BITS;
            default: bl_len = (COL_BITS+1)'(1);
        endcase
    endfunction : bl_len

    // wraps inside the burst-sized block, so the upper column bits never move
    function automatic logic [COL_BITS-1:0] col_gen(input logic [COL_BITS-1:0] start,
                                                    input logic [COL_BITS-1:0] cnt,
                                                    input logic [COL_BITS:0] len,
                                                    input logic inter);
        logic [COL_BITS-1:0] m;
        m = COL_BITS'(len - (COL_BITS+1)'(1));
        if (inter) begin
            col_gen = (start & ~m) | ((start ^ cnt) & m);
        end else begin
            col_gen = (start & ~m) | ((start + cnt) & m);
        end
    endfunction : col_gen

    always_comb begin
        cl_use = st_q.mode[MODE_CL_LSB +: 3];
        if (cl_use < CL_MIN) begin
            cl_use = CL_MIN;
        end else if (cl_use > CL_MAX) begin
            cl_use = CL_MAX;
        end
    end

    assign full_pg = st_q.bst_len[COL_BITS];
    assign acc_idx = {acc_bank, st_q.row[acc_bank], acc_col};
    assign rd_word = mem[acc_idx];
    assign rvld = acc_en && !acc_wr;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        acc_en = 1'b0;
        acc_wr = st_q.bst_wr;
        acc_last = 1'b0;
        acc_ap = st_q.bst_ap;
        acc_bank = st_q.bst_bank;
        acc_col = '0;
        new_len = bl_len(st_q.mode[MODE_BL_LSB +: 3]);
        case (st_q.pwr)
            PWR_RUN: begin
                st_d.mask_q = mask_in;
                if (st_q.bst_act) begin
                    acc_en = 1'b1;
                    acc_col = col_gen(st_q.bst_col, st_q.bst_cnt, st_q.bst_len,
                                      st_q.mode[MODE_BT_BIT]);
                    acc_last = !full_pg && ({1'b0, st_q.bst_cnt} ==
                                            st_q.bst_len - (COL_BITS+1)'(1));
                    st_d.bst_cnt = st_q.bst_cnt + COL_BITS'(1);
                    if (acc_last) begin
                        st_d.bst_act = 1'b0;
                    end
                end
                if (!cs_n) begin
                    case (cmd)
                        CMD_ACT: begin
                            st_d.bank_open[ba] = 1'b1;
                            st_d.row[ba] = addr[ROW_BITS-1:0];
                        end
                        CMD_RD, CMD_WR: begin
                            // ignored unless the controller has opened a row in this bank first
                            if (st_q.bank_open[ba]) begin
                                acc_en = 1'b1;
                                acc_wr = (cmd == CMD_WR);
                                acc_bank = ba;
                                acc_col = addr[COL_BITS-1:0];
                                acc_ap = addr[AP_BIT];
                                if (acc_wr && st_q.mode[MODE_WB_BIT]) begin
                                    new_len = (COL_BITS+1)'(1);
                                end
                                acc_last = (new_len == (COL_BITS+1)'(1));
                                st_d.bst_act = !acc_last;
                                st_d.bst_wr = acc_wr;
                                st_d.bst_ap = acc_ap;
                                st_d.bst_bank = ba;
                                st_d.bst_col = acc_col;
                                st_d.bst_cnt = COL_BITS'(1);
                                st_d.bst_len = new_len;
                            end
                        end
                        CMD_BST: begin
                            acc_en = 1'b0;
                            st_d.bst_act = 1'b0;
                        end
                        CMD_PRE: begin
                            if (addr[AP_BIT]) begin
                                st_d.bank_open = '0;
                            end else begin
                                st_d.bank_open[ba] = 1'b0;
                            end
                            // other banks keep bursting through a precharge
                            if (addr[AP_BIT] || ba == st_q.bst_bank) begin
                                acc_en = 1'b0;
                                st_d.bst_act = 1'b0;
                            end
                        end
                        CMD_LMR: begin
                            if (st_q.bank_open == '0) begin
                                st_d.mode = {ba, addr};
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (acc_en && acc_last && acc_ap) begin
                    st_d.bank_open[acc_bank] = 1'b0;
                end
                // read latency pipeline
                st_d.pvld[0] = rvld;
                st_d.pdat[0] = rd_word;
                for (int k = 1; k < PIPE_D; k++) begin
                    st_d.pvld[k] = st_q.pvld[k-1];
                    st_d.pdat[k] = st_q.pdat[k-1];
                end
                if (cl_use == CL_MIN) begin
                    st_d.dout = rd_word;
                    st_d.dvld = rvld;
                end else begin
                    st_d.dout = st_q.pdat[int'(cl_use) - 2];
                    st_d.dvld = st_q.pvld[int'(cl_use) - 2];
                end
                st_d.doe_n = {LANES{~st_d.dvld}} | st_q.mask_q;
                if (!cke) begin
                    if (st_d.bst_act || st_d.pvld != '0) begin
                        st_d.pwr = PWR_SUSPEND;
                    end else if (!cs_n && cmd == CMD_REF) begin
                        st_d.pwr = PWR_SELF_REF;
                    end else if (st_d.bank_open != '0) begin
                        st_d.pwr = PWR_PD_ACT;
                    end else begin
                        st_d.pwr = PWR_PD_PRE;
                    end
                end
            end
            PWR_SUSPEND, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF_REF: begin
                // frozen: every other input is ignored until clock enable returns
                if (cke) begin
                    st_d.pwr = PWR_RUN;
                end
            end
            default: begin
                st_d.pwr = PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // array has no reset; contents are undefined until written
    always_ff @(posedge ref_clk) begin
        for (int g = 0; g < LANES; g++) begin
            if (acc_en && acc_wr && !mask_in[g]) begin
                mem[acc_idx][g*8 +: 8] <= data_lines_in[g*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [IDX_W-1:0] idx_q;
    always_ff @(posedge ref_clk) begin
        idx_q <= acc_idx;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_cs_mask;
        cs_n && st_q.pwr == PWR_RUN && !st_q.bst_act |=> $stable(st_q.mode) && $stable(st_q.bank_open);
    endproperty
    a_cs_mask: assert property (p_cs_mask) else $error("command taken with chip select high");
    property p_act_row;
        st_q.pwr == PWR_RUN && cmd == CMD_ACT |=>
            st_q.bank_open[$past(ba)] && st_q.row[$past(ba)] == $past(addr[ROW_BITS-1:0]);
    endproperty
    a_act_row: assert property (p_act_row) else $error("activate did not open row");
    property p_pre_all;
        st_q.pwr == PWR_RUN && cmd == CMD_PRE && addr[AP_BIT] |=> st_q.bank_open == '0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
    property p_pre_one;
        st_q.pwr == PWR_RUN && cmd == CMD_PRE && !addr[AP_BIT] |=> !st_q.bank_open[$past(ba)];
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("selected bank not closed");
    property p_lmr;
        st_q.pwr == PWR_RUN && cmd == CMD_LMR && st_q.bank_open == '0 |=>
            st_q.mode == $past({ba, addr});
    endproperty
    a_lmr: assert property (p_lmr) else $error("mode op-code not loaded");
    property p_rd_lat2;
        rvld && st_q.pwr == PWR_RUN && cl_use == 3'h2 && cke |=> ##1 st_q.dvld;
    endproperty
    a_rd_lat2: assert property (p_rd_lat2) else $error("read data late");
    property p_mask_z;
        lower_byte_mask && st_q.pwr == PWR_RUN && cke |=> ##1 data_lines_oe_n[0];
    endproperty
    a_mask_z: assert property (p_mask_z) else $error("masked read byte driven");
    property p_wr_keep;
        acc_en && acc_wr && upper_byte_mask && st_q.pwr == PWR_RUN |=>
            mem[idx_q][15:8] == $past(rd_word[15:8]);
    endproperty
    a_wr_keep: assert property (p_wr_keep) else $error("masked byte overwritten");
    property p_ap_close;
        acc_en && acc_last && acc_ap && st_q.pwr == PWR_RUN && cmd != CMD_ACT |=>
            !st_q.bank_open[$past(acc_bank)];
    endproperty
    a_ap_close: assert property (p_ap_close) else $error("auto precharge missing");
    property p_burst2;
        (st_q.pwr == PWR_RUN && cmd == CMD_RD && st_q.bank_open[ba] && cke &&
         st_q.mode[2:0] == BL_2) ##1 (cs_n && st_q.pwr == PWR_RUN) |->
            acc_en && acc_col == ($past(addr[COL_BITS-1:0]) ^ COL_BITS'(1)) ##1 !st_q.bst_act;
    endproperty
    a_burst2: assert property (p_burst2) else $error("two-word burst wrong");
    property p_suspend;
        st_q.pwr == PWR_SUSPEND |=> $stable(data_lines_out) && $stable(st_q.bst_cnt);
    endproperty
    a_suspend: assert property (p_suspend) else $error("state moved in suspend");

    c_read: cover property (rvld ##[1:3] st_q.dvld);
    c_apwrite: cover property (acc_en && acc_wr && acc_last && acc_ap);
    c_selfref: cover property (st_q.pwr == PWR_SELF_REF ##[1:20] st_q.pwr == PWR_RUN);
endmodule : sdc_sdram_device
`default_nettype wire

// [verif/sdc_ctrl_model.sv]
// controller-side partner model: drives command, address, mask and write data pins
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model (
    input wire logic ref_clk,
    output var logic cke,
    output var logic cs_n,
    output var logic ras_n,
    output var logic cas_n,
    output var logic we_n,
    output var logic bank_sel_0,
    output var logic bank_sel_1,
    output var logic [sdc_pkg::ADDR_W-1:0] addr,
    output var logic lower_byte_mask,
    output var logic upper_byte_mask,
    output var logic [sdc_pkg::DATA_W-1:0] data_lines_in
);
    import sdc_pkg::*;
    // ------------------------------------------------------------
    // pin driving, always just after the falling edge
    // ------------------------------------------------------------
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
        {bank_sel_1, bank_sel_0} = 2'h0;
        addr = 13'h0000;
        {upper_byte_mask, lower_byte_mask} = 2'h0;
        data_lines_in = 16'h0000;
    end
    task automatic issue(input logic [3:0] c, input logic [1:0] b,
                         input logic [ADDR_W-1:0] a, input logic [1:0] m,
                         input logic [DATA_W-1:0] d);
        @(negedge ref_clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        {bank_sel_1, bank_sel_0} = b;
        addr = a;
        {upper_byte_mask, lower_byte_mask} = m;
        data_lines_in = d;
    endtask : issue
    // address and data lines toggle so a stale value never looks valid; bank selects go low
    task automatic idle(input logic [1:0] m);
        issue(CMD_NOP, 2'h0, ~addr, m, ~data_lines_in);
    endtask : idle
    task automatic set_cke(input logic v);
        cke = v;
    endtask : set_cke
    // ------------------------------------------------------------
    // start-up: quiet time, precharge all, two refreshes, mode load
    // ------------------------------------------------------------
    task automatic init_seq(input logic [MODE_W-1:0] mode);
        repeat (INIT_CYCLES) idle(2'h0);
        issue(CMD_PRE, 2'h0, 13'h0400, 2'h0, 16'h0000);
        repeat (2) begin
            issue(CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0000);
            idle(2'h0);
        end
        issue(CMD_LMR, mode[14:13], mode[12:0], 2'h0, 16'h0000);
        idle(2'h0);
    endtask : init_seq
endmodule : sdc_ctrl_model
`default_nettype wire

// [verif/tb_sdram_command_addressing.sv]
// self-checking bench for the synchronous dram device
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_command_addressing;
    import sdc_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    wire logic cke, cs_n, ras_n, cas_n, we_n, bank_sel_0, bank_sel_1;
    wire logic lower_byte_mask, upper_byte_mask;
    wire logic [ADDR_W-1:0] addr;
    wire logic [DATA_W-1:0] data_lines_in;
    wire logic [DATA_W-1:0] data_lines_out;
    wire logic [LANES-1:0] data_lines_oe_n;
    int fail_count = 0;
    int comparisons = 0;
    always #20 ref_clk = ~ref_clk;
    sdc_ctrl_model u_ctrl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1),
        .addr(addr), .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
        .data_lines_in(data_lines_in));
    // small array keeps the simulator light
    sdc_sdram_device #(.ROW_BITS(4), .COL_BITS(4)) uut (.ref_clk(ref_clk), .nrst(nrst),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .addr(addr),
        .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n));
    // ------------------------------------------------------------
    // comparisons and verdict
    // ------------------------------------------------------------
    task automatic chk_word(input string what, input logic [DATA_W-1:0] e,
                            input logic [DATA_W-1:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk_word
    task automatic chk_oe(input string what, input logic [1:0] e, input logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask : chk_oe
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // transfers: mode is burst of two, read latency two
    // ------------------------------------------------------------
    task automatic act(input logic [1:0] b, input logic [3:0] row);
        u_ctrl.issue(CMD_ACT, b, {9'h000, row}, 2'h0, 16'h0000);
    endtask : act
    task automatic wr2(input logic [1:0] b, input logic [3:0] col, input logic [1:0] m0,
                       input logic [15:0] d0, input logic [1:0] m1, input logic [15:0] d1);
        u_ctrl.issue(CMD_WR, b, {9'h000, col}, m0, d0);
        u_ctrl.issue(CMD_NOP, 2'h0, 13'h0000, m1, d1);
        u_ctrl.idle(2'h0);
    endtask : wr2
    // m1 masks the second word two clocks ahead of its output slot
    task automatic rd2(input logic [1:0] b, input logic [3:0] col, input logic ap,
                       input logic [1:0] m1, input logic [15:0] e0, input logic [15:0] e1);
        u_ctrl.issue(CMD_RD, b, {2'h0, ap, 6'h00, col}, 2'h0, 16'h0000);
        u_ctrl.idle(m1);
        u_ctrl.idle(2'h0);
        chk_oe("lanes of first word", 2'h0, data_lines_oe_n);
        chk_word("first word", e0, data_lines_out);
        u_ctrl.idle(2'h0);
        chk_oe("lanes of second word", m1, data_lines_oe_n);
        chk_word("low byte of second word", {8'h00, e1[7:0]}, {8'h00, data_lines_out[7:0]});
        if (m1 == 2'h0) chk_word("second word", e1, data_lines_out);
        u_ctrl.idle(2'h0);
        chk_oe("lanes after burst", 2'h3, data_lines_oe_n);
    endtask : rd2
    task automatic no_rd(input logic [1:0] b, input logic [3:0] col);
        u_ctrl.issue(CMD_RD, b, {9'h000, col}, 2'h0, 16'h0000);
        repeat (4) begin
            u_ctrl.idle(2'h0);
            chk_oe("lanes of refused read", 2'h3, data_lines_oe_n);
        end
    endtask : no_rd
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_basic;
        act(2'h1, 4'h3);
        wr2(2'h1, 4'h2, 2'h0, 16'h1234, 2'h0, 16'habcd);
        rd2(2'h1, 4'h2, 1'b0, 2'h0, 16'h1234, 16'habcd);
        rd2(2'h1, 4'h3, 1'b0, 2'h0, 16'habcd, 16'h1234);
    endtask : s_basic
    task automatic s_masks;
        wr2(2'h1, 4'h2, 2'h1, 16'h5566, 2'h2, 16'h7788);
        rd2(2'h1, 4'h2, 1'b0, 2'h0, 16'h5534, 16'hab88);
        rd2(2'h1, 4'h2, 1'b0, 2'h2, 16'h5534, 16'hab88);
    endtask : s_masks
    task automatic s_cs;
        u_ctrl.issue(4'hc, 2'h1, 13'h0002, 2'h0, 16'hdead);
        u_ctrl.issue(4'hd, 2'h1, 13'h0002, 2'h0, 16'hbeef);
        rd2(2'h1, 4'h2, 1'b0, 2'h0, 16'h5534, 16'hab88);
    endtask : s_cs
    task automatic s_pre;
        act(2'h0, 4'h1);
        wr2(2'h0, 4'h0, 2'h0, 16'h0f0f, 2'h0, 16'hf0f0);
        u_ctrl.issue(CMD_PRE, 2'h0, 13'h0000, 2'h0, 16'h0000);
        no_rd(2'h0, 4'h0);
        rd2(2'h1, 4'h2, 1'b0, 2'h0, 16'h5534, 16'hab88);
        u_ctrl.issue(CMD_PRE, 2'h2, 13'h0400, 2'h0, 16'h0000);
        no_rd(2'h1, 4'h2);
    endtask : s_pre
    task automatic s_auto_pre;
        act(2'h1, 4'h3);
        rd2(2'h1, 4'h2, 1'b1, 2'h0, 16'h5534, 16'hab88);
        no_rd(2'h1, 4'h2);
    endtask : s_auto_pre
    task automatic s_power_down;
        act(2'h1, 4'h3);
        u_ctrl.set_cke(1'b0);
        u_ctrl.idle(2'h0);
        no_rd(2'h1, 4'h2);
        u_ctrl.set_cke(1'b1);
        u_ctrl.idle(2'h0);
        rd2(2'h1, 4'h2, 1'b0, 2'h0, 16'h5534, 16'hab88);
    endtask : s_power_down
    // terminate on the edge after the read: second word never fetched
    task automatic s_bst;
        u_ctrl.issue(CMD_RD, 2'h1, 13'h0002, 2'h0, 16'h0000);
        u_ctrl.issue(CMD_BST, 2'h0, 13'h0000, 2'h0, 16'h0000);
        u_ctrl.idle(2'h0);
        chk_word("first word before stop", 16'h5534, data_lines_out);
        u_ctrl.idle(2'h0);
        chk_oe("lanes after stop", 2'h3, data_lines_oe_n);
    endtask : s_bst
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        u_ctrl.init_seq(15'h0021);
        s_basic();
        s_masks();
        s_cs();
        s_pre();
        s_auto_pre();
        s_power_down();
        s_bst();
        tally_and_finish();
    end
    initial begin
        #(40 * (INIT_CYCLES + 2000));
        fail_count++;
        $display("unexpected watchdog: expected run end seen no end");
        tally_and_finish();
    end
endmodule : tb_sdram_command_addressing
`default_nettype wire
